// *** vsc_defs.svh ***
// Purpose: Constants of the output level and first control register bank
// Assumes: 20 MHz system clock, serial link clocked by its own clock line
// Notes: Offsets, reset values and timing counts as macros
// Notes on behaviour
// R1: Loop-select 1: divider feedback, fixed reference
// R2: Loop-select 0: reference from code, divider off
// R3: Start-up always in divider feedback regulation
// R4: Reset: loop-select 1, code 001 1110
// R5: Code maps linearly, 0.6 V plus 7.5 mV steps
// R6: Code write accepted only while grant set
// R7: Grant self-clears when reference command completes
// R8: Grant set forces PWM, then mode returns
// R9: Enable bit 0 stops both switches
// R10: Enable pin low: converter off, link off
// R11: Slew field sets reference ramp rate
// R12: Retry set: recover once over-voltage removed
// R13: Retry clear: latch off until enable toggles
// R14: Over-current plus under-voltage: hiccup or latch
// R15: Mode bit: 0 auto skip, 1 forced PWM
// R16: Start, address, register, data; ack each byte
// R17: Commit on falling clock of last data bit
// R18: Grant reads 1 while ramping, 0 when done
// R19: Refused code write leaves code and output alone; code still writes the loop-select bit, which can move o_level and o_ref_uv
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

// ==========================================
// Clock
`define VSC_CLK_MHZ 20

// ==========================================
// Link address and register offsets
`define VSC_SLV_ADDR 7'h60
`define VSC_REG_LEVEL 8'h00
`define VSC_REG_SYS1 8'h01

// ==========================================
// Reset values
`define VSC_LEVEL_RST 8'h9e
`define VSC_SYS1_RST 8'ha6

// ==========================================
// Reference mapping in microvolts
`define VSC_REF_BASE_UV 21'h927c0
`define VSC_REF_STEP_UV 21'h01d4c

// ==========================================
// Timing
`define VSC_STEP_BASE_NS 1000
`define VSC_STEP_BASE_CYC ((`VSC_STEP_BASE_NS * `VSC_CLK_MHZ + 999) / 1000)
`define VSC_HICCUP_US 1000
`define VSC_HICCUP_CYC (`VSC_HICCUP_US * `VSC_CLK_MHZ)

`endif

// *** vsc_pkg.sv ***
// Purpose: Types of the output level and control register bank
// Assumes: Nothing
// Notes: Register layouts as packed structs
package vsc_pkg;

  typedef struct packed {
    logic fb_loop;
    logic [6:0] code;
  } vsc_level_t;

  typedef struct packed {
    logic en;
    logic go;
    logic [2:0] slew;
    logic ovp_retry;
    logic ocp_hiccup;
    logic fpwm;
  } vsc_sys1_t;

  typedef struct packed {
    logic ovp_out;
    logic ovp_in;
    logic ocp;
    logic uvp;
  } vsc_fault_t;

  typedef enum logic [3:0] {
    VSC_ST_IDLE = 4'h0,
    VSC_ST_ADDR = 4'h1,
    VSC_ST_ACK_ADDR = 4'h2,
    VSC_ST_REG = 4'h3,
    VSC_ST_ACK_REG = 4'h4,
    VSC_ST_WDAT = 4'h5,
    VSC_ST_ACK_WDAT = 4'h6,
    VSC_ST_RDAT = 4'h7,
    VSC_ST_MACK = 4'h8
  } vsc_bus_st_t;

endpackage

// *** vsc_link_cap.sv ***
// Purpose: Bit capture on the serial link clock
// Assumes: Data line stable while the link clock is high
// Notes: Each rising edge stores one bit and flips a toggle
module vsc_link_cap (
  input wire logic i_scl_clk,
  input wire logic i_rst_n,
  input wire logic i_sda,
  output logic o_bit,
  output logic o_tog
);

  logic bit_q, bit_d, tog_q, tog_d;

  // ==========================================
  // Capture
  always_comb begin
    bit_d = i_sda;
    tog_d = ~tog_q;
  end

  // Reset acts at once: the link clock stands still between frames
  always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_q <= 1'b1;
      tog_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      tog_q <= tog_d;
    end
  end

  assign o_bit = bit_q;
  assign o_tog = tog_q;

endmodule // vsc_link_cap

// *** vsc_ramp.sv ***
`include "vsc_defs.svh"
// Purpose: Reference code ramp at a selectable slew rate
// Assumes: System clock
// Notes: Jump input loads the target at once
module vsc_ramp #(
  parameter int BASE_CYC = `VSC_STEP_BASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_jump,
  input wire logic [6:0] i_target,
  input wire logic [2:0] i_slew,
  output logic [6:0] o_code,
  output logic o_done
);

  logic [6:0] cur_q, cur_d;
  logic [15:0] tmr_q, tmr_d;

  // ==========================================
  // Step timer and code
  always_comb begin
    cur_d = cur_q;
    tmr_d = (tmr_q == 16'h0000) ? 16'h0000 : tmr_q - 16'h0001;
    if (i_jump) begin
      cur_d = i_target;
      tmr_d = 16'h0000;
    end else if (cur_q != i_target && tmr_q == 16'h0000) begin
      cur_d = (cur_q < i_target) ? cur_q + 7'h01 : cur_q - 7'h01; // [R11]
      tmr_d = 16'(BASE_CYC * (int'(i_slew) + 1) - 1); // [R11]
    end
    if (!i_rst_n) begin
      cur_d = 7'(`VSC_LEVEL_RST);
      tmr_d = 16'h0000;
    end
  end

  always_ff @(posedge i_clk) begin
    cur_q <= cur_d;
    tmr_q <= tmr_d;
  end

  assign o_code = cur_q;
  assign o_done = (cur_q == i_target);

  a_ramp_step: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R11]
    !$past(i_jump) |-> (cur_q == $past(cur_q) || cur_q == $past(cur_q) + 7'h01
      || cur_q == $past(cur_q) - 7'h01))
    else $error("ramp moved more than one step");

endmodule // vsc_ramp

// *** vsc_regs.sv ***
`include "vsc_defs.svh"
// Purpose: Output level and first system control registers behind the serial link
// Assumes: Link clock is the serial clock line; pins and fault inputs asynchronous
// Notes: Link bits cross by toggle; framing runs on the system clock
module vsc_regs #(
  parameter logic [6:0] SLV_ADDR = `VSC_SLV_ADDR,
  parameter int HICCUP_CYC = `VSC_HICCUP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl_clk,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic i_en_pin,
  input wire vsc_pkg::vsc_fault_t i_fault,
  output vsc_pkg::vsc_level_t o_level,
  output logic [20:0] o_ref_uv,
  output logic o_high_side_switch_en,
  output logic o_low_side_switch_en,
  output logic o_forced_pwm,
  output logic o_latched_off,
  output logic o_hiccup_active
);

  localparam int HW = $clog2(HICCUP_CYC + 1);

  // ==========================================
  // Link capture and synchronisers
  logic link_bit, link_tog;
  logic [7:0] s1_q, s2_q;
  logic scl_p_q, sda_p_q, tog_p_q;
  logic scl_s, sda_s, en_s, tog_s;
  vsc_pkg::vsc_fault_t flt_s;

  vsc_link_cap u_cap (
    .i_scl_clk(i_scl_clk),
    .i_rst_n(i_rst_n),
    .i_sda(i_sda),
    .o_bit(link_bit),
    .o_tog(link_tog)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_q <= 8'h03;
      s2_q <= 8'h03;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      tog_p_q <= 1'b0;
    end else begin
      s1_q <= {link_tog, i_fault, i_en_pin, i_sda, i_scl_clk};
      s2_q <= s1_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      tog_p_q <= tog_s;
    end
  end

  assign scl_s = s2_q[0];
  assign sda_s = s2_q[1];
  assign en_s = s2_q[2];
  assign flt_s = vsc_pkg::vsc_fault_t'(s2_q[6:3]);
  assign tog_s = s2_q[7];

  logic start_ev, stop_ev, fall_ev, bit_ev;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign fall_ev = scl_p_q & ~scl_s;
  assign bit_ev = tog_s ^ tog_p_q;

  // ==========================================
  // Registers
  vsc_pkg::vsc_level_t lvl_q, lvl_d;
  vsc_pkg::vsc_sys1_t sys_q, sys_d;
  logic pend_q, pend_d;
  logic ramp_done;
  logic [6:0] ramp_code;

  function automatic logic [7:0] rd_fn(input logic [7:0] a, input vsc_pkg::vsc_level_t l,
                                       input vsc_pkg::vsc_sys1_t s);
    logic [7:0] r;
    r = 8'h00;
    if (a == `VSC_REG_LEVEL) begin
      r = l;
    end else if (a == `VSC_REG_SYS1) begin
      r = s;
    end
    return r;
  endfunction

  // ==========================================
  // Link framing
  vsc_pkg::vsc_bus_st_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d, ptr_q, ptr_d, rd_byte;
  logic rw_q, rw_d, mack_q, mack_d, oe_n_q, oe_n_d, wr_stb;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    mack_d = mack_q;
    oe_n_d = oe_n_q;
    wr_stb = 1'b0;
    rd_byte = 8'h00;
    if (!en_s) begin
      st_d = vsc_pkg::VSC_ST_IDLE; // [R10]
      oe_n_d = 1'b1;
    end else if (start_ev) begin
      st_d = vsc_pkg::VSC_ST_ADDR; // [R16]
      cnt_d = 4'h0;
      oe_n_d = 1'b1;
    end else if (stop_ev) begin
      st_d = vsc_pkg::VSC_ST_IDLE;
      oe_n_d = 1'b1;
    end else begin
      unique case (st_q)
        vsc_pkg::VSC_ST_IDLE: begin
        end
        vsc_pkg::VSC_ST_ADDR, vsc_pkg::VSC_ST_REG, vsc_pkg::VSC_ST_WDAT: begin
          if (bit_ev && cnt_q != 4'h8) begin
            sr_d = {sr_q[6:0], link_bit};
            cnt_d = cnt_q + 4'h1;
          end else if (fall_ev && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            oe_n_d = 1'b0; // [R16]
            if (st_q == vsc_pkg::VSC_ST_ADDR) begin
              rw_d = sr_q[0];
              if (sr_q[7:1] == SLV_ADDR) begin
                st_d = vsc_pkg::VSC_ST_ACK_ADDR;
              end else begin
                st_d = vsc_pkg::VSC_ST_IDLE;
                oe_n_d = 1'b1;
              end
            end else if (st_q == vsc_pkg::VSC_ST_REG) begin
              ptr_d = sr_q;
              st_d = vsc_pkg::VSC_ST_ACK_REG;
            end else begin
              wr_stb = 1'b1; // [R17]
              st_d = vsc_pkg::VSC_ST_ACK_WDAT;
            end
          end
        end
        vsc_pkg::VSC_ST_ACK_ADDR: begin
          if (fall_ev) begin
            oe_n_d = 1'b1;
            st_d = vsc_pkg::VSC_ST_REG;
            if (rw_q) begin
              rd_byte = rd_fn(ptr_q, lvl_q, sys_q); // [R18]
              sr_d = rd_byte;
              oe_n_d = rd_byte[7];
              st_d = vsc_pkg::VSC_ST_RDAT;
            end
          end
        end
        vsc_pkg::VSC_ST_ACK_REG: begin
          if (fall_ev) begin
            oe_n_d = 1'b1;
            st_d = vsc_pkg::VSC_ST_WDAT;
          end
        end
        vsc_pkg::VSC_ST_ACK_WDAT: begin
          if (fall_ev) begin
            oe_n_d = 1'b1;
            ptr_d = ptr_q + 8'h01;
            st_d = vsc_pkg::VSC_ST_WDAT;
          end
        end
        vsc_pkg::VSC_ST_RDAT: begin
          if (fall_ev) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              oe_n_d = 1'b1;
              st_d = vsc_pkg::VSC_ST_MACK;
            end else begin
              sr_d = {sr_q[6:0], 1'b1};
              oe_n_d = sr_q[6];
            end
          end
        end
        vsc_pkg::VSC_ST_MACK: begin
          if (bit_ev) begin
            mack_d = link_bit;
          end else if (fall_ev) begin
            cnt_d = 4'h0;
            st_d = vsc_pkg::VSC_ST_IDLE;
            if (!mack_q) begin
              ptr_d = ptr_q + 8'h01;
              rd_byte = rd_fn(ptr_q + 8'h01, lvl_q, sys_q);
              sr_d = rd_byte;
              oe_n_d = rd_byte[7];
              st_d = vsc_pkg::VSC_ST_RDAT;
            end
          end
        end
        default: begin
          st_d = vsc_pkg::VSC_ST_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= vsc_pkg::VSC_ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      mack_q <= mack_d;
      oe_n_q <= oe_n_d;
    end
  end

  // ==========================================
  // Register update
  always_comb begin
    lvl_d = lvl_q;
    sys_d = sys_q;
    pend_d = pend_q;
    if (pend_q && ramp_done) begin
      sys_d.go = 1'b0; // [R7] [R18]
      pend_d = 1'b0;
    end
    if (wr_stb && ptr_q == `VSC_REG_LEVEL) begin
      lvl_d.fb_loop = sr_q[7]; // [R1] [R2]
      if (sys_q.go) begin
        lvl_d.code = sr_q[6:0]; // [R6] [R19]
        pend_d = 1'b1;
      end
    end
    if (wr_stb && ptr_q == `VSC_REG_SYS1) begin
      sys_d = vsc_pkg::vsc_sys1_t'(sr_q);
    end
    if (!en_s) begin
      lvl_d = vsc_pkg::vsc_level_t'(`VSC_LEVEL_RST); // [R3] [R10]
      sys_d = vsc_pkg::vsc_sys1_t'(`VSC_SYS1_RST);
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lvl_q <= vsc_pkg::vsc_level_t'(`VSC_LEVEL_RST); // [R4]
      sys_q <= vsc_pkg::vsc_sys1_t'(`VSC_SYS1_RST);
      pend_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      sys_q <= sys_d;
      pend_q <= pend_d;
    end
  end

  vsc_ramp u_ramp (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_jump(lvl_q.fb_loop),
    .i_target(lvl_q.code),
    .i_slew(sys_q.slew),
    .o_code(ramp_code),
    .o_done(ramp_done)
  );

  // ==========================================
  // Protection and switching
  logic latch_q, latch_d, run;
  logic [HW-1:0] hic_q, hic_d;

  always_comb begin
    latch_d = latch_q;
    hic_d = (hic_q == '0) ? '0 : hic_q - HW'(1);
    if (!sys_q.ovp_retry && flt_s.ovp_out && flt_s.ovp_in) begin
      latch_d = 1'b1; // [R13]
    end
    if (flt_s.ocp && flt_s.uvp) begin
      if (!sys_q.ocp_hiccup) begin
        latch_d = 1'b1; // [R14]
      end else if (hic_q == '0) begin
        hic_d = HW'(HICCUP_CYC); // [R14]
      end
    end
    if (!en_s) begin
      latch_d = 1'b0; // [R13]
      hic_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      latch_q <= 1'b0;
      hic_q <= '0;
    end else begin
      latch_q <= latch_d;
      hic_q <= hic_d;
    end
  end

  assign run = en_s & sys_q.en & ~latch_q & ~flt_s.ovp_out & (hic_q == '0); // [R9] [R12]

  // ==========================================
  // Output registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_level <= vsc_pkg::vsc_level_t'(`VSC_LEVEL_RST);
      o_ref_uv <= `VSC_REF_BASE_UV;
      o_high_side_switch_en <= 1'b0;
      o_low_side_switch_en <= 1'b0;
      o_forced_pwm <= 1'b0;
      o_latched_off <= 1'b0;
      o_hiccup_active <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_oe_n <= oe_n_q;
      o_level <= {lvl_q.fb_loop, ramp_code};
      o_ref_uv <= lvl_q.fb_loop ? `VSC_REF_BASE_UV : // [R1]
        `VSC_REF_BASE_UV + 21'(ramp_code) * `VSC_REF_STEP_UV; // [R2] [R5]
      o_high_side_switch_en <= run; // [R9]
      o_low_side_switch_en <= run;
      o_forced_pwm <= sys_q.go | sys_q.fpwm; // [R8] [R15]
      o_latched_off <= latch_q;
      o_hiccup_active <= (hic_q != '0);
    end
  end

  // ==========================================
  // Assertions
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_byte_end;
    fall_ev && cnt_q == 4'h8 && st_q != vsc_pkg::VSC_ST_IDLE && st_q != vsc_pkg::VSC_ST_MACK;
  endsequence

  a_ref_fixed: assert property (o_level.fb_loop |-> o_ref_uv == `VSC_REF_BASE_UV) // [R1]
    else $error("divider loop reference not fixed");
  a_ref_map: assert property (!o_level.fb_loop |-> // [R2] [R5]
    o_ref_uv == `VSC_REF_BASE_UV + 21'(o_level.code) * `VSC_REF_STEP_UV)
    else $error("reference does not follow code");
  a_reset_vals: assert property ($past(!i_rst_n) |-> // [R3] [R4]
    lvl_q == vsc_pkg::vsc_level_t'(`VSC_LEVEL_RST) && lvl_q.fb_loop)
    else $error("level register not at reset value");
  a_code_guard: assert property (wr_stb && ptr_q == `VSC_REG_LEVEL // [R6] [R19]
    && !sys_q.go && en_s |=> lvl_q.code == $past(lvl_q.code))
    else $error("code changed without grant");
  a_go_clear: assert property (pend_q && ramp_done && en_s // [R7]
    && !(wr_stb && ptr_q == `VSC_REG_SYS1) |=> !sys_q.go)
    else $error("grant not cleared after scaling");
  a_go_hold: assert property (sys_q.go && !ramp_done && en_s && !wr_stb |=> sys_q.go) // [R18]
    else $error("grant dropped while ramping");
  a_fpwm: assert property (sys_q.go |=> o_forced_pwm) // [R8]
    else $error("no forced pwm while scaling");
  a_mode: assert property (!sys_q.go && !sys_q.fpwm |=> !o_forced_pwm) // [R15]
    else $error("forced pwm without mode or grant");
  a_sw_off: assert property (!sys_q.en |=> !o_high_side_switch_en && !o_low_side_switch_en) // [R9]
    else $error("switching with enable bit low");
  a_pin_off: assert property (!en_s |=> !o_high_side_switch_en // [R10]
    && st_q == vsc_pkg::VSC_ST_IDLE ##1 o_sda_oe_n)
    else $error("active with enable pin low");
  a_latch: assert property (latch_q && en_s |=> latch_q ##0 !o_high_side_switch_en) // [R13]
    else $error("latch released without enable toggle");
  a_hiccup: assert property (en_s && flt_s.ocp && flt_s.uvp && sys_q.ocp_hiccup // [R14]
    && hic_q == '0 |=> hic_q == HW'(HICCUP_CYC))
    else $error("hiccup not started");
  a_ovp_retry: assert property (flt_s.ovp_out |=> !o_high_side_switch_en) // [R12]
    else $error("switching during over-voltage");
  a_ack_drive: assert property (s_byte_end ##0 (st_q != vsc_pkg::VSC_ST_ADDR // [R16]
    || sr_q[7:1] == SLV_ADDR) && en_s && !start_ev && !stop_ev |=> ##1 !o_sda_oe_n)
    else $error("byte not acknowledged");
  a_commit: assert property (s_byte_end ##0 st_q == vsc_pkg::VSC_ST_WDAT && en_s // [R17]
    && !start_ev && !stop_ev |-> wr_stb)
    else $error("write not committed at last bit");

endmodule // vsc_regs

// *** vsc_host_model.sv ***
// Purpose: Host model that frames two-wire transfers
// Assumes: Data line pulled up; one half bit is HALF link ticks
// Notes: Clock line stands high between frames
module vsc_host_model #(
  parameter int HALF = 100
) (
  input wire logic i_lclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // ==========================================
  // Bit timing
  task automatic wt(input int n);
    repeat (n) @(posedge i_lclk);
    #1;
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start();
    if (!o_scl) begin
      wt(HALF / 4);
      o_sda_low = 1'b0;
      wt(HALF);
      o_scl = 1'b1;
    end
    wt(HALF);
    o_sda_low = 1'b1;
    wt(HALF);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    wt(HALF / 4);
    o_sda_low = 1'b1;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_low = 1'b0;
    wt(HALF);
  endtask

  // One byte MSB first plus the ninth bit; data changes only with clock low
  task automatic xbyte(input logic [7:0] d, input logic nine, output logic [7:0] r,
                       output logic ack);
    logic [8:0] tx;
    tx = {d, nine};
    for (int i = 8; i >= 0; i--) begin
      wt(HALF / 4);
      o_sda_low = !tx[i];
      wt(HALF);
      o_scl = 1'b1;
      wt(HALF);
      if (i > 0) begin
        r[i-1] = i_sda;
      end else begin
        ack = i_sda;
      end
      o_scl = 1'b0;
    end
  endtask
endmodule // vsc_host_model

// *** vsc_regs_tb.sv ***
`include "vsc_defs.svh"
// Purpose: Self-checking bench of the output level and control registers
// Assumes: Host model frames all link traffic
// Notes: Hiccup off-time shortened to 50 cycles
module vsc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clk = 1'b0;
  logic lclk = 1'b0;
  logic i_rst_n = 1'b1;
  logic en_pin = 1'b1;
  vsc_pkg::vsc_fault_t fault = '0;
  vsc_pkg::vsc_level_t level;
  logic [20:0] ref_uv;
  logic scl, sda_low, sda, sda_out, sda_oe_n, hs, ls, fpwm, latched, hiccup;
  int fails = 0;
  int total_checks = 0;
  int seed = 32'hed5a;
  logic [7:0] d, s1;
  logic [6:0] code;
  logic mode, go;

  always #25 i_clk = ~i_clk;
  always #7.5 lclk = ~lclk;
  assign sda = !sda_low && (sda_oe_n || sda_out);

  vsc_regs #(.HICCUP_CYC(50)) vsc_regs_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl_clk(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_en_pin(en_pin), .i_fault(fault),
    .o_level(level), .o_ref_uv(ref_uv), .o_high_side_switch_en(hs),
    .o_low_side_switch_en(ls), .o_forced_pwm(fpwm), .o_latched_off(latched),
    .o_hiccup_active(hiccup)
  );
  vsc_host_model #(.HALF(84)) vsc_host_model_i (
    .i_lclk(lclk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
  );

  // ==========================================
  // Helpers
  function automatic logic [20:0] ref_exp(input logic fb, input logic [6:0] c);
    ref_exp = fb ? 21'h927c0 : 21'h927c0 + 21'(c) * 21'h01d4c;
  endfunction

  task automatic chk(input string m, input logic [20:0] g, input logic [20:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic at(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v,
                    input logic nak);
    logic [7:0] x;
    logic k;
    vsc_host_model_i.start();
    vsc_host_model_i.xbyte({a, 1'b0}, 1'b1, x, k);
    chk("address ack", k, nak);
    vsc_host_model_i.xbyte(r, 1'b1, x, k);
    if (!nak) chk("register ack", k, 1'b0);
    vsc_host_model_i.xbyte(v, 1'b1, x, k);
    if (!nak) chk("data ack", k, 1'b0);
    vsc_host_model_i.stop();
  endtask

  task automatic rd(input logic [7:0] r, output logic [7:0] v);
    logic [7:0] x;
    logic k;
    vsc_host_model_i.start();
    vsc_host_model_i.xbyte({`VSC_SLV_ADDR, 1'b0}, 1'b1, x, k);
    vsc_host_model_i.xbyte(r, 1'b1, x, k);
    vsc_host_model_i.start();
    vsc_host_model_i.xbyte({`VSC_SLV_ADDR, 1'b1}, 1'b1, x, k);
    chk("read ack", k, 1'b0);
    vsc_host_model_i.xbyte(8'hff, 1'b1, v, k);
    vsc_host_model_i.stop();
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    #1;
    i_rst_n = 1'b0;
    at(3);
    i_rst_n = 1'b1;
    chk("reset level", level, 8'h9e);
    chk("reset ref", ref_uv, 21'h927c0);
    at(10);
    chk("switching", {hs, ls, fpwm}, 3'h6);
    rd(8'h00, d);
    chk("read level", d, 8'h9e);
    rd(8'h01, d);
    chk("read control", d, 8'ha6);
    rd(8'h02, d);
    chk("unmapped", d, 8'h00);
    wr(`VSC_SLV_ADDR, 8'h00, 8'h05, 1'b0);
    chk("refused code", level, 8'h1e);
    chk("refused ref", ref_uv, ref_exp(1'b0, 7'h1e));
    for (int k = 0; k < 6; k++) begin
      code = (k == 0) ? 7'h00 : (k == 1) ? 7'h7f : 7'($random(seed));
      mode = 1'($random(seed));
      s1 = {2'h3, (k == 1) ? 3'h7 : 3'h0, 2'h3, mode};
      wr(`VSC_SLV_ADDR, 8'h01, s1, 1'b0);
      chk("grant pwm", fpwm, 1'b1);
      wr(`VSC_SLV_ADDR, 8'h00, {1'b0, code}, 1'b0);
      go = 1'b1;
      for (int n = 0; n < 16 && go === 1'b1; n++) begin
        rd(8'h01, d);
        go = d[6];
        if (k == 1 && n == 0) chk("grant in ramp", go, 1'b1);
      end
      if (go !== 1'b0) begin
        fails++;
        $display("Error at %0t: grant never cleared", $time);
        print_verdict();
      end
      chk("control after", d, s1 & 8'hbf);
      chk("scaled level", level, {1'b0, code});
      chk("scaled ref", ref_uv, ref_exp(1'b0, code));
      chk("mode back", fpwm, mode);
    end
    wr(`VSC_SLV_ADDR, 8'h00, 8'h85, 1'b0);
    chk("loop bit", level, {1'b1, code});
    chk("loop ref", ref_uv, 21'h927c0);
    wr(`VSC_SLV_ADDR, 8'h01, 8'h26, 1'b0);
    at(5);
    chk("enable off", {hs, ls}, 2'h0);
    wr(`VSC_SLV_ADDR, 8'h01, 8'ha6, 1'b0);
    at(5);
    chk("enable on", {hs, ls}, 2'h3);
    fault.ovp_out = 1'b1;
    at(6);
    chk("ovp off", hs, 1'b0);
    fault = '0;
    at(6);
    chk("ovp retry", {hs, latched}, 2'h2);
    fault.ocp = 1'b1;
    fault.uvp = 1'b1;
    at(6);
    chk("hiccup on", {hiccup, hs}, 2'h2);
    fault = '0;
    at(70);
    chk("hiccup end", {hiccup, hs}, 2'h1);
    wr(`VSC_SLV_ADDR, 8'h01, 8'ha0, 1'b0);
    fault.ovp_out = 1'b1;
    fault.ovp_in = 1'b1;
    at(6);
    fault = '0;
    at(6);
    chk("ovp latch", {latched, hs}, 2'h2);
    en_pin = 1'b0;
    at(6);
    chk("pin off", {hs, ls}, 2'h0);
    wr(`VSC_SLV_ADDR, 8'h01, 8'ha6, 1'b1);
    en_pin = 1'b1;
    at(10);
    chk("pin toggle", {latched, hs}, 2'h1);
    chk("pin level", level, 8'h9e);
    wr(`VSC_SLV_ADDR, 8'h01, 8'ha4, 1'b0);
    fault.ocp = 1'b1;
    fault.uvp = 1'b1;
    at(6);
    fault = '0;
    at(70);
    chk("ocp latch", {latched, hs, hiccup}, 3'h4);
    wr(7'h61, 8'h01, 8'ha6, 1'b1);
    print_verdict();
  end
endmodule // vsc_regs_tb
